// *** hdl/rcc_map.vh ***
`ifndef RCC_MAP_VH
`define RCC_MAP_VH
// pointer addresses
`define RCC_ADDR_IDEAL    8'h23
`define RCC_ADDR_MAKER_ID 8'hfe
`define RCC_ADDR_OFFSET   8'h11
`define RCC_ADDR_CHAN_EN  8'h16
`define RCC_ADDR_CFG_RD   8'h03
`define RCC_ADDR_CFG_WR   8'h09
// field positions
`define RCC_CHAN_REMOTE_BIT 1
`define RCC_CFG_RANGE_BIT   2
// reset values
`define RCC_IDEAL_RST    8'h00
`define RCC_OFFSET_RST   12'h000
`define RCC_CHAN_EN_RST  8'h03
`define RCC_CFG_RST      8'h00
// ideality scale: nominal 1.008 held as q2.16, base count 2088
`define RCC_IDEAL_NOM_Q  18'h1020c
`define RCC_IDEAL_BASE   12'h828
// extended range adds 64 degrees (64 * 16 lsb)
`define RCC_EXT_SHIFT    12'h400
`endif

// *** hdl/rcc_div.v ***
`timescale 1ns/1ps
// ****************************************
// sequential restoring divider
// ****************************************
module rcc_div #(
    parameter NW = 32,
    parameter DW = 12
) (
    input  wire          i_clk_sys,
    input  wire          i_rst_n,
    input  wire          i_start,
    input  wire [NW-1:0] i_num,
    input  wire [DW-1:0] i_den,
    output reg           o_done,
    output reg  [NW-1:0] o_quo
);
    reg [NW-1:0] num_q;
    reg [DW:0]   rem_q;
    reg [5:0]    cnt_q;
    reg          busy_q;
    wire [DW:0]  trial = {rem_q[DW-1:0], num_q[NW-1]};

    // one quotient bit per cycle, NW cycles per divide
    always @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            num_q  <= {NW{1'b0}};
            rem_q  <= {(DW+1){1'b0}};
            cnt_q  <= 6'h00;
            busy_q <= 1'b0;
            o_done <= 1'b0;
            o_quo  <= {NW{1'b0}};
        end
        else
        begin
            o_done <= 1'b0;
            if (i_start && !busy_q)
            begin
                num_q  <= i_num;
                rem_q  <= {(DW+1){1'b0}};
                cnt_q  <= NW[5:0];
                busy_q <= 1'b1;
            end
            else if (busy_q)
            begin
                if (trial >= {1'b0, i_den})
                begin
                    rem_q <= trial - {1'b0, i_den};
                    num_q <= {num_q[NW-2:0], 1'b1};
                end
                else
                begin
                    rem_q <= trial;
                    num_q <= {num_q[NW-2:0], 1'b0};
                end
                cnt_q <= cnt_q - 6'h01;
                if (cnt_q == 6'h01)
                begin
                    busy_q <= 1'b0;
                    o_done <= 1'b1;
                    o_quo  <= (trial >= {1'b0, i_den}) ? {num_q[NW-2:0], 1'b1} : {num_q[NW-2:0], 1'b0};
                end
            end
        end
    end
endmodule

// *** hdl/rcc_top.v ***
`timescale 1ns/1ps
`include "rcc_map.vh"
module rcc_top #(
    parameter [7:0] MAKER_ID = 8'h5a  // arbitrary neutral value
) (
    input  wire        i_clk_sys,
    input  wire        i_rst_n,
    input  wire        i_wr,
    input  wire        i_rd,
    input  wire [7:0]  i_ptr,
    input  wire [7:0]  i_wdata,
    input  wire        i_conv_start,
    input  wire        i_conv_remote,
    input  wire [11:0] i_raw_temp,
    output reg  [7:0]  o_rdata,
    output reg         o_rvalid,
    output reg         o_busy,
    output reg         o_res_valid,
    output reg         o_res_remote,
    output reg  [11:0] o_res_temp,
    output reg  [17:0] o_ideal_eff
);
    // ****************************************
    // registers
    // ****************************************
    // register images; the offset keeps its written byte in the top eight bits
    reg [7:0]  ideal_q;
    reg [11:0] offset_q;
    reg [7:0]  chan_q;
    reg [7:0]  cfg_q;

    // host writes; maker id pointer has no write path
    always @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            ideal_q  <= `RCC_IDEAL_RST;
            offset_q <= `RCC_OFFSET_RST;
            chan_q   <= `RCC_CHAN_EN_RST;
            cfg_q    <= `RCC_CFG_RST;
        end
        else if (i_wr)
        begin
            case (i_ptr)
                `RCC_ADDR_IDEAL:   ideal_q  <= i_wdata;
                `RCC_ADDR_OFFSET:  offset_q <= {i_wdata, 4'h0};
                `RCC_ADDR_CHAN_EN: chan_q   <= {6'h00, i_wdata[1:0]};
                `RCC_ADDR_CFG_WR:  cfg_q    <= {5'h00, i_wdata[2], 2'h0};
                default:           ideal_q  <= ideal_q;
            endcase
        end
    end

    // ****************************************
    // read path
    // ****************************************
    // read port, one cycle latency; data holds until the next read so a slow
    // host can pick it up late without a second strobe
    always @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_rdata  <= 8'h00;
            o_rvalid <= 1'b0;
        end
        else
        begin
            o_rvalid <= i_rd;
            if (i_rd)
            begin
                case (i_ptr)
                    `RCC_ADDR_IDEAL:    o_rdata <= ideal_q;
                    `RCC_ADDR_MAKER_ID: o_rdata <= MAKER_ID;
                    `RCC_ADDR_OFFSET:   o_rdata <= offset_q[11:4];
                    `RCC_ADDR_CHAN_EN:  o_rdata <= chan_q;
                    `RCC_ADDR_CFG_RD:   o_rdata <= cfg_q;
                    default:            o_rdata <= 8'h00;
                endcase
            end
        end
    end

    // ****************************************
    // conversion pipeline
    // ****************************************
    // sequencer states
    localparam ST_IDLE = 2'h0;
    localparam ST_DIV  = 2'h1;
    localparam ST_OUT  = 2'h2;

    reg  [1:0]  st_q;
    reg  [7:0]  adj_snap_q;
    reg  [11:0] off_snap_q;
    reg  [11:0] raw_q;
    reg         range_q;
    reg         div_start_q;
    wire        div_done;
    wire [31:0] div_quo;

    // ****************************************
    // ideality divider
    // ****************************************
    // sign-extended adjust added to base 2088; the sum stays between 1960 and 2215,
    // so it never reaches zero and twelve bits always hold it
    wire [11:0] den = `RCC_IDEAL_BASE + {{4{adj_snap_q[7]}}, adj_snap_q};
    // numerator 1.008*2088 in q2.16, scaled so quotient is q2.16
    wire [31:0] num = {14'h0000, `RCC_IDEAL_NOM_Q} * {20'h00000, `RCC_IDEAL_BASE};

    // serial divide: one quotient bit a cycle trades latency for a small divider
    rcc_div #(.NW(32), .DW(12)) u_div (
        .i_clk_sys (i_clk_sys),
        .i_rst_n   (i_rst_n),
        .i_start   (div_start_q),
        .i_num     (num),
        .i_den     (den),
        .o_done    (div_done),
        .o_quo     (div_quo)
    );

    // ****************************************
    // result arithmetic
    // ****************************************
    // scale a raw reading by eta_eff/1.008, then add the offset; the scaling works on
    // the magnitude so readings below zero are scaled by the same factor as positive ones
    function [11:0] rcc_apply;
        input [11:0] raw;
        input [17:0] eta;
        input [11:0] off;
        input        ext;
        reg   [31:0] prod;
        reg   [11:0] base;
        reg   [11:0] mag;
        reg          neg;
        begin
            // extended encoding carries a 64 degree bias; take it off before scaling
            base = ext ? raw - `RCC_EXT_SHIFT : raw;
            neg  = base[11];
            mag  = neg ? 12'h000 - base : base;
            prod = ({2'b00, mag} * {14'h0000, eta}) / {14'h0000, `RCC_IDEAL_NOM_Q};
            // scaled values past the top of the range wrap; the host must keep
            // the adjustment small enough for its hottest reading
            rcc_apply = (neg ? 12'h000 - prod[11:0] : prod[11:0]) + off + (ext ? `RCC_EXT_SHIFT : 12'h000);
        end
    endfunction

    // ****************************************
    // conversion sequencer
    // ****************************************
    // snapshot settings at start, so later writes wait for the next conversion;
    // a start that arrives while busy is dropped, the host must wait for idle
    // before it asks again
    always @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            st_q         <= ST_IDLE;
            adj_snap_q   <= 8'h00;
            off_snap_q   <= 12'h000;
            raw_q        <= 12'h000;
            range_q      <= 1'b0;
            div_start_q  <= 1'b0;
            o_busy       <= 1'b0;
            o_res_valid  <= 1'b0;
            o_res_remote <= 1'b0;
            o_res_temp   <= 12'h000;
            o_ideal_eff  <= `RCC_IDEAL_NOM_Q;
        end
        else
        begin
            div_start_q <= 1'b0;
            o_res_valid <= 1'b0;
            case (st_q)
                ST_IDLE:
                begin
                    // local results pass straight through
                    if (i_conv_start && !i_conv_remote)
                    begin
                        o_res_valid  <= 1'b1;
                        o_res_remote <= 1'b0;
                        o_res_temp   <= i_raw_temp;
                    end
                    // remote start only with the channel enabled
                    else if (i_conv_start && chan_q[`RCC_CHAN_REMOTE_BIT])
                    begin
                        adj_snap_q  <= ideal_q;
                        off_snap_q  <= offset_q;
                        range_q     <= cfg_q[`RCC_CFG_RANGE_BIT];
                        raw_q       <= i_raw_temp;
                        div_start_q <= 1'b1;
                        o_busy      <= 1'b1;
                        st_q        <= ST_DIV;
                    end
                end
                ST_DIV:
                begin
                    // hold here until the divider hands back the quotient
                    if (div_done)
                    begin
                        o_ideal_eff <= div_quo[17:0];
                        st_q        <= ST_OUT;
                    end
                end
                // result and busy drop land on the same edge
                ST_OUT:
                begin
                    o_res_valid  <= 1'b1;
                    o_res_remote <= 1'b1;
                    o_res_temp   <= rcc_apply(raw_q, o_ideal_eff, off_snap_q, range_q);
                    o_busy       <= 1'b0;
                    st_q         <= ST_IDLE;
                end
                default:
                    st_q <= ST_IDLE;
            endcase
        end
    end
endmodule

// *** bench/rcc_host.sv ***
`timescale 1ns/1ps
// ****
// two-wire host stand-in
// ****
module rcc_host (
    input  wire logic       i_clk_sys,
    output logic            o_wr,
    output logic            o_rd,
    output logic [7:0]      o_ptr,
    output logic [7:0]      o_wdata
);
    // one-cycle strobe; lines scrambled after so stale values never pass
    task xfer(input logic w, input logic [7:0] p, input logic [7:0] d);
        @(negedge i_clk_sys);
        o_wr = w;
        o_rd = !w;
        o_ptr = p;
        o_wdata = d;
        @(negedge i_clk_sys);
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_ptr = ~p;
        o_wdata = ~d;
    endtask
    // quiet bus at time zero
    initial
    begin
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_ptr = 8'h00;
        o_wdata = 8'h00;
    end
endmodule

// *** bench/rcc_properties.sv ***
`timescale 1ns/1ps
// ****
// port checker
// ****
module rcc_properties #(
    parameter [7:0] MAKER_ID = 8'h00
) (
    input wire        i_clk_sys,
    input wire        i_rst_n,
    input wire        i_wr,
    input wire        i_rd,
    input wire [7:0]  i_ptr,
    input wire [7:0]  i_wdata,
    input wire        i_conv_start,
    input wire        i_conv_remote,
    input wire [11:0] i_raw_temp,
    input wire [7:0]  o_rdata,
    input wire        o_rvalid,
    input wire        o_busy,
    input wire        o_res_valid,
    input wire        o_res_remote,
    input wire [11:0] o_res_temp,
    input wire [17:0] o_ideal_eff
);
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rst_n);
    // register bus answers and holds
    property p_rvalid; i_rd |=> o_rvalid; endproperty
    a_rvalid: assert property (p_rvalid) else $error("read answer missing");
    property p_hold; !i_rd |=> $stable(o_rdata); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_maker; i_rd && i_ptr == 8'hfe |=> o_rdata == MAKER_ID; endproperty
    a_maker: assert property (p_maker) else $error("maker code wrong");
    property p_nom; $rose(i_rst_n) |-> o_ideal_eff == 18'h1020c; endproperty
    a_nom: assert property (p_nom) else $error("nominal ideality wrong");
    // local path must bypass correction and offset
    property p_local; i_conv_start && !i_conv_remote && !o_busy |=> o_res_valid && !o_res_remote
        && o_res_temp == $past(i_raw_temp); endproperty
    a_local: assert property (p_local) else $error("local result altered");
    property p_done; $fell(o_busy) |-> o_res_valid && o_res_remote; endproperty
    a_done: assert property (p_done) else $error("remote end without result");
    property p_span; $rose(o_busy) |-> ##[1:40] o_res_valid; endproperty
    a_span: assert property (p_span) else $error("remote result late");
    property p_eff; !o_busy |=> $stable(o_ideal_eff); endproperty
    a_eff: assert property (p_eff) else $error("ideality changed while idle");
    c_remote: cover property (o_res_valid && o_res_remote);
    c_local: cover property (o_res_valid && !o_res_remote);
    c_maker: cover property (i_rd && i_ptr == 8'hfe);
endmodule
bind rcc_top rcc_properties #(.MAKER_ID(MAKER_ID)) u_props (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
    .i_wr(i_wr), .i_rd(i_rd), .i_ptr(i_ptr), .i_wdata(i_wdata), .i_conv_start(i_conv_start),
    .i_conv_remote(i_conv_remote), .i_raw_temp(i_raw_temp), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
    .o_busy(o_busy), .o_res_valid(o_res_valid), .o_res_remote(o_res_remote), .o_res_temp(o_res_temp),
    .o_ideal_eff(o_ideal_eff));

// *** bench/testbench.sv ***
`timescale 1ns/1ps
module testbench;
    localparam logic [7:0] ID = 8'h3c; // arbitrary value
    logic i_clk_sys, i_rst_n, i_wr, i_rd, i_conv_start, i_conv_remote, o_rvalid, o_busy, o_res_valid, o_res_remote;
    logic [7:0]  i_ptr, i_wdata, o_rdata;
    logic [11:0] i_raw_temp, o_res_temp, raw;
    logic [17:0] o_ideal_eff;
    wire  [30:0] res_seen = {o_res_remote, o_res_temp, o_ideal_eff};
    logic [7:0]  rq[$];
    logic [30:0] cq[$];
    int          failures, compares, r;
    rcc_host u_host (.i_clk_sys(i_clk_sys), .o_wr(i_wr), .o_rd(i_rd), .o_ptr(i_ptr), .o_wdata(i_wdata));
    rcc_top #(.MAKER_ID(ID)) u_dut (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_wr(i_wr), .i_rd(i_rd),
        .i_ptr(i_ptr), .i_wdata(i_wdata), .i_conv_start(i_conv_start), .i_conv_remote(i_conv_remote),
        .i_raw_temp(i_raw_temp), .o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_busy(o_busy),
        .o_res_valid(o_res_valid), .o_res_remote(o_res_remote), .o_res_temp(o_res_temp),
        .o_ideal_eff(o_ideal_eff));
    // ****
    // helpers
    // ****
    task chk(input string n, input logic [30:0] s, input logic [30:0] e);
        compares++;
        if (s !== e)
        begin
            failures++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    task summarize;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task rd(input logic [7:0] p, input logic [7:0] e);
        rq.push_back(e);
        u_host.xfer(1'b0, p, 8'h00);
    endtask
    // waits on busy with a bound so a stuck divider cannot hang the run
    task conv(input logic m, input logic [11:0] w, input logic [11:0] t, input logic [17:0] e, input bit y);
        @(negedge i_clk_sys);
        i_conv_start = 1'b1;
        i_conv_remote = m;
        i_raw_temp = w;
        if (y) cq.push_back({m, t, e});
        @(negedge i_clk_sys);
        i_conv_start = 1'b0;
        i_raw_temp = ~w;
        for (int k = 0; k < 60 && o_busy === 1'b1; k++) @(negedge i_clk_sys);
        chk("idle", o_busy, 1'b0);
        @(negedge i_clk_sys);
    endtask
    // outputs checked at the falling edge, oldest note first
    always @(negedge i_clk_sys)
    begin
        if (o_rvalid === 1'b1) chk("rdata", o_rdata, rq.size() ? rq.pop_front() : 'x);
        if (o_res_valid === 1'b1) chk("result", res_seen, cq.size() ? cq.pop_front() : 'x);
    end
    initial
    begin
        i_clk_sys = 1'b0;
        forever #2.5 i_clk_sys = ~i_clk_sys;
    end
    // a hang counts as a failure
    initial
    begin
        #100us;
        failures++;
        summarize;
    end
    initial
    begin
        r = $urandom(32'hf811);
        i_rst_n = 1'b0;
        i_conv_start = 1'b0;
        i_conv_remote = 1'b0;
        i_raw_temp = 12'h000;
        repeat (3) @(negedge i_clk_sys);
        i_rst_n = 1'b1;
        rd(8'h23, 8'h00);
        rd(8'hfe, ID);
        u_host.xfer(1'b1, 8'hfe, ~ID);
        rd(8'hfe, ID);
        rd(8'h40, 8'h00);
        for (int i = 0; i < 3; i++)
        begin
            r = (i == 0) ? 32'h7f : (i == 1) ? 32'h80 : $urandom;
            u_host.xfer(1'b1, 8'h23, r[7:0]);
            rd(8'h23, r[7:0]);
        end
        $display("register test done");
        raw = 12'($urandom % 1792);
        u_host.xfer(1'b1, 8'h23, 8'h00);
        conv(1'b0, raw, raw, 18'h1020c, 1);
        conv(1'b1, raw, raw, 18'h1020c, 1);
        u_host.xfer(1'b1, 8'h11, 8'h02);
        conv(1'b1, raw, raw + 12'h020, 18'h1020c, 1);
        u_host.xfer(1'b1, 8'h11, 8'h00);
        u_host.xfer(1'b1, 8'h23, 8'h80);
        conv(1'b1, 12'h000, 12'h000, 18'h112e6, 1);
        conv(1'b0, raw, raw, 18'h112e6, 1);
        u_host.xfer(1'b1, 8'h23, 8'h7f);
        fork
            conv(1'b1, 12'h000, 12'h000, 18'h0f340, 1);
            u_host.xfer(1'b1, 8'h23, 8'h00);
        join
        conv(1'b1, raw, raw, 18'h1020c, 1);
        u_host.xfer(1'b1, 8'h16, 8'h01);
        conv(1'b1, raw, raw, 18'h1020c, 0);
        chk("busy", o_busy, 1'b0);
        $display("conversion test done");
        // remote enabled again; a mid-scale reading shows the scaling, then the range bias
        u_host.xfer(1'b1, 8'h16, 8'h03);
        rd(8'h16, 8'h03);
        u_host.xfer(1'b1, 8'h23, 8'h80);
        conv(1'b1, 12'h400, 12'h442, 18'h112e6, 1);
        u_host.xfer(1'b1, 8'h09, 8'h04);
        rd(8'h03, 8'h04);
        conv(1'b1, 12'h400, 12'h400, 18'h112e6, 1);
        u_host.xfer(1'b1, 8'h11, 8'h01);
        conv(1'b1, 12'h400, 12'h410, 18'h112e6, 1);
        $display("range test done");
        chk("left", cq.size() + rq.size(), 0);
        summarize;
    end
endmodule
